// >>> cfgio_pkg.sv
// Constants and types shared by the configurable I/O port block.
package cfgio_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Geometry.
	localparam int NUM_PORTS = 3;
	localparam int PORT_W    = 8;
	localparam int ADDR_W    = 4;

	typedef logic [NUM_PORTS-1:0][PORT_W-1:0] cfgio_portvec_t;

	////////////////////////////////////////////////////////////////////////////////
	// Register map: address bits [3:2] pick the port slot, bits [1:0] the register.
	localparam logic [1:0]        SUB_LATCH     = 2'h0;
	localparam logic [1:0]        SUB_CFG1      = 2'h1;
	localparam logic [1:0]        SUB_CFG2      = 2'h2;
	localparam logic [1:0]        SUB_INPUT     = 2'h3;
	localparam logic [ADDR_W-1:0] ADDR_P0_LATCH = 4'h0;
	localparam logic [ADDR_W-1:0] ADDR_P0_CFG1  = 4'h1;
	localparam logic [ADDR_W-1:0] ADDR_P0_INPUT = 4'h3;
	localparam logic [ADDR_W-1:0] ADDR_ADIS     = 4'hC;
	localparam logic [ADDR_W-1:0] ADDR_AVAIL_P0 = 4'hD;
	localparam logic [ADDR_W-1:0] ADDR_AVAIL_P1 = 4'hE;
	localparam logic [ADDR_W-1:0] ADDR_AVAIL_P3 = 4'hF;

	////////////////////////////////////////////////////////////////////////////////
	// Output types, encoded as {cfg1 bit, cfg2 bit}.
	typedef enum logic [1:0] {
		CFGIO_QUASI     = 2'b00,
		CFGIO_PUSHPULL  = 2'b01,
		CFGIO_INONLY    = 2'b10,
		CFGIO_OPENDRAIN = 2'b11
	} cfgio_otype_t;

	// Reset values: every pin input-only, latches high, digital inputs enabled.
	localparam logic [PORT_W-1:0] CFG1_RST  = 8'hFF;
	localparam logic [PORT_W-1:0] CFG2_RST  = 8'h00;
	localparam logic [PORT_W-1:0] LATCH_RST = 8'hFF;
	localparam logic [PORT_W-1:0] ADIS_RST  = 8'h00;

	////////////////////////////////////////////////////////////////////////////////
	// Pins that exist: slot 0 is port 0, slot 1 port 1, slot 2 port 3.
	localparam cfgio_portvec_t IMPL_MASK = {8'h03, 8'h20, 8'h70};
	localparam int RST_PORT     = 1;
	localparam int RST_BIT      = 5;
	localparam int XTAL_PORT    = 2;
	localparam int XTAL_OUT_BIT = 0;
	localparam int XTAL_IN_BIT  = 1;

	// Clock source strap codes; 2'h3 behaves as a crystal.
	localparam logic [1:0] CLK_ONCHIP  = 2'h0;
	localparam logic [1:0] CLK_EXTIN   = 2'h1;
	localparam logic [1:0] CLK_CRYSTAL = 2'h2;

	////////////////////////////////////////////////////////////////////////////////
	// Timing.
	localparam int CLK_PERIOD_NS = 10;
	localparam int GLITCH_NS     = 50;
	localparam int GLITCH_CYC    = (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// >>> cfgio_glitch_filter.sv
// Per-bit hysteresis and glitch suppression filter for synchronised pin levels.
module cfgio_glitch_filter
	import cfgio_pkg::*;
#(
	parameter int W        = 24,
	parameter int FILT_CYC = GLITCH_CYC
) (
	input  wire logic         clk_sys,  // System clock.
	input  wire logic         sys_rst,  // Synchronous reset, active high.
	input  wire logic [W-1:0] pinSync,  // Synchronised pin levels.
	output logic      [W-1:0] pinClean  // Filtered pin levels.
);

	localparam int CW = $clog2(FILT_CYC + 1);

	typedef struct packed {
		logic [W-1:0][CW-1:0] cnt;
		logic [W-1:0]         clean;
	} cfgio_filt_t;

	cfgio_filt_t          st;
	cfgio_filt_t          next_st;
	logic [W-1:0][CW-1:0] nextCnt;
	logic [W-1:0]         nextClean;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	////////////////////////////////////////////////////////////////////////////////
	// A bit follows its input only after it has differed for FILT_CYC cycles in a row.
	for (genvar i = 0; i < W; i++) begin : g_bit
		logic diff;
		logic done;
		assign diff = pinSync[i] ^ st.clean[i];
		assign done = diff && (st.cnt[i] == CW'(FILT_CYC - 1));
		assign nextCnt[i] = (!diff || done) ? '0 : CW'(st.cnt[i] + 1'b1); // R8
		assign nextClean[i] = done ? pinSync[i] : st.clean[i]; // R8

		a_glitch_stable: assert property ($changed(st.clean[i]) |-> // R8
			($past(pinSync[i]) == st.clean[i]) && ($past(pinSync[i], FILT_CYC) == st.clean[i]))
			else $error("filtered pin changed without a stable input");
	end

	always_comb begin
		next_st = st;
		next_st.cnt = nextCnt;
		next_st.clean = nextClean;
		if (sys_rst) begin
			next_st = '0;
		end
	end

	always_ff @(posedge clk_sys) begin
		st <= next_st;
	end

	assign pinClean = st.clean;

endmodule

// >>> cfgio_port.sv
// Configurable I/O port block: latches, output type selection, pin drivers and inputs.
//
// Function
// [R1] Every pin but the reset-shared pin can be set by software to quasi, push-pull, open-drain or input-only.
// [R2] Each port has two configuration registers whose bit pairs select each pin's output type.
// [R3] The reset-shared pin is input only and its output type cannot be changed.
// [R4] Quasi type drives a latched one weakly and a latched zero strongly.
// [R5] Open-drain type never pulls up and pulls down only while the latch holds zero.
// [R6] Input-only type enables no driver at all, leaving the pin floating.
// [R7] Push-pull type pulls up strongly on a latched one and pulls down on a latched zero.
// [R8] Every pin input passes a hysteresis and glitch filter before internal logic sees it.
// [R9] Port 0 has one digital-input disable bit per pin, all cleared by any reset.
// [R10] Software using a pin for the comparator disables its digital input and sets it input-only.
// [R11] The usable pin count follows clock source and reset option, from six down to three.
// [R12] Software and board must choose the external reset pin when running above 12 MHz.
// [R13] After reset every pin is input-only until software changes it.
// [R14] A port input read returns each pin's filtered level whatever its type or latch.
//
// Added by the designer: the strobed register port and the placing of the registers.
module cfgio_port
	import cfgio_pkg::*;
#(
	parameter int FILT_CYC = GLITCH_CYC
) (
	input  wire logic                  clk_sys,        // System clock, 100 MHz.
	input  wire logic                  sys_rst,        // Synchronous reset, active high.
	input  wire logic [ADDR_W-1:0]     regAddr,        // Register address.
	input  wire logic [PORT_W-1:0]     regWrData,      // Register write data.
	input  wire logic                  regWr,          // Write strobe.
	input  wire logic                  regRd,          // Read strobe.
	output logic      [PORT_W-1:0]     regRdData,      // Read data, the cycle after regRd.
	input  wire logic [1:0]            clkSrcSel,      // Clock source option, caught at reset.
	input  wire logic                  resetPinEnable, // Reset pin option, caught at reset.
	input  wire cfgio_portvec_t        pinIn,          // Pin levels from the pads.
	output cfgio_portvec_t             pinOut,         // Strong drive level.
	output cfgio_portvec_t             pinOe,          // Strong drive enable.
	output cfgio_portvec_t             pinWeakPullUp,  // Weak pull-up enable.
	output logic      [PORT_W-1:0]     pinDigInEn      // Port 0 digital input buffer enable.
);

	typedef struct packed {
		cfgio_portvec_t    latch;
		cfgio_portvec_t    cfg1;
		cfgio_portvec_t    cfg2;
		cfgio_portvec_t    sync1;
		cfgio_portvec_t    sync2;
		cfgio_portvec_t    pinOut;
		cfgio_portvec_t    pinOe;
		cfgio_portvec_t    pinWeak;
		logic [PORT_W-1:0] adis;
		logic [PORT_W-1:0] rdData;
		logic [1:0]        clkSrc;
		logic              rstPinEn;
	} cfgio_state_t;

	cfgio_state_t         st;
	cfgio_state_t         next_st;
	cfgio_portvec_t       avail;
	cfgio_portvec_t       clean;
	cfgio_portvec_t       inVal;
	logic [1:0]           slot;
	logic [1:0]           sub;
	logic                 slotOk;

	////////////////////////////////////////////////////////////////////////////////
	// Pins left usable by the clock source and reset pin options.
	function automatic cfgio_portvec_t availOf(logic [1:0] src, logic rpe);
		cfgio_portvec_t m;
		m = IMPL_MASK;
		if (rpe) begin
			m[RST_PORT][RST_BIT] = 1'b0; // R11
		end
		if (src != CLK_ONCHIP) begin
			m[XTAL_PORT][XTAL_IN_BIT] = 1'b0; // R11
		end
		if (src[1]) begin
			m[XTAL_PORT][XTAL_OUT_BIT] = 1'b0; // R11
		end
		return m;
	endfunction

	assign avail  = availOf(st.clkSrc, st.rstPinEn);
	assign slot   = regAddr[3:2];
	assign sub    = regAddr[1:0];
	assign slotOk = (slot != 2'h3);

	////////////////////////////////////////////////////////////////////////////////
	// Input path: two flip-flops, then the filter.
	cfgio_glitch_filter #(
		.W        (NUM_PORTS * PORT_W),
		.FILT_CYC (FILT_CYC)
	) u_filter (
		.clk_sys  (clk_sys),
		.sys_rst  (sys_rst),
		.pinSync  (st.sync2),
		.pinClean (clean)
	);

	// Filtered level regardless of type or latch; disabled port 0 inputs read zero.
	always_comb begin
		inVal = clean & avail; // R14
		inVal[0] = inVal[0] & ~st.adis; // R9
	end

	////////////////////////////////////////////////////////////////////////////////
	// Next-state logic.
	always_comb begin
		cfgio_otype_t ot;
		ot = CFGIO_INONLY;
		next_st = st;
		next_st.sync1 = pinIn;
		next_st.sync2 = st.sync1;
		next_st.rdData = 8'h00;

		if (regWr && slotOk) begin
			case (sub)
				SUB_LATCH: begin
					next_st.latch[slot] = regWrData & IMPL_MASK[slot];
				end
				SUB_CFG1: begin
					next_st.cfg1[slot] = regWrData & IMPL_MASK[slot]; // R1 R2
				end
				SUB_CFG2: begin
					next_st.cfg2[slot] = regWrData & IMPL_MASK[slot]; // R1 R2
				end
				default: begin
				end
			endcase
		end
		if (regWr && (regAddr == ADDR_ADIS)) begin
			next_st.adis = regWrData & IMPL_MASK[0]; // R9
		end
		// The reset-shared pin keeps input-only whatever is written.
		next_st.cfg1[RST_PORT][RST_BIT] = 1'b1; // R3
		next_st.cfg2[RST_PORT][RST_BIT] = 1'b0; // R3

		if (regRd) begin
			case (regAddr)
				ADDR_ADIS:     next_st.rdData = st.adis;
				ADDR_AVAIL_P0: next_st.rdData = avail[0];
				ADDR_AVAIL_P1: next_st.rdData = avail[1];
				ADDR_AVAIL_P3: next_st.rdData = avail[2];
				default: begin
					case (sub)
						SUB_LATCH: next_st.rdData = st.latch[slot];
						SUB_CFG1:  next_st.rdData = st.cfg1[slot];
						SUB_CFG2:  next_st.rdData = st.cfg2[slot];
						default:   next_st.rdData = inVal[slot]; // R14
					endcase
				end
			endcase
		end

		// Pad drivers from the new latch and configuration.
		for (int p = 0; p < NUM_PORTS; p++) begin
			for (int b = 0; b < PORT_W; b++) begin
				ot = avail[p][b] ? cfgio_otype_t'({next_st.cfg1[p][b], next_st.cfg2[p][b]})
					: CFGIO_INONLY; // R1 R11
				next_st.pinOut[p][b] = 1'b0;
				next_st.pinOe[p][b] = 1'b0;
				next_st.pinWeak[p][b] = 1'b0;
				case (ot)
					CFGIO_QUASI: begin
						next_st.pinWeak[p][b] = next_st.latch[p][b]; // R4
						next_st.pinOe[p][b] = ~next_st.latch[p][b]; // R4
					end
					CFGIO_PUSHPULL: begin
						next_st.pinOe[p][b] = 1'b1; // R7
						next_st.pinOut[p][b] = next_st.latch[p][b]; // R7
					end
					CFGIO_OPENDRAIN: begin
						next_st.pinOe[p][b] = ~next_st.latch[p][b]; // R5
					end
					default: begin
						next_st.pinOe[p][b] = 1'b0; // R6
					end
				endcase
			end
		end

		if (sys_rst) begin
			next_st = '0;
			for (int p = 0; p < NUM_PORTS; p++) begin
				next_st.latch[p] = LATCH_RST & IMPL_MASK[p];
				next_st.cfg1[p] = CFG1_RST & IMPL_MASK[p]; // R13
				next_st.cfg2[p] = CFG2_RST;
			end
			next_st.adis = ADIS_RST; // R9
			next_st.clkSrc = clkSrcSel;
			next_st.rstPinEn = resetPinEnable;
		end
	end

	always_ff @(posedge clk_sys) begin
		st <= next_st;
	end

	assign regRdData     = st.rdData;
	assign pinOut        = st.pinOut;
	assign pinOe         = st.pinOe;
	assign pinWeakPullUp = st.pinWeak;
	assign pinDigInEn    = avail[0] & ~st.adis; // R9

	////////////////////////////////////////////////////////////////////////////////
	// Assertions, watched on port 0 bit 4 where a single pin is needed, except the reset-shared pin check on port 1 bit 5.
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	a_quasi_low: assert property ((regWr && regAddr == ADDR_P0_LATCH && !regWrData[4] // R4
		&& !st.cfg1[0][4] && !st.cfg2[0][4] && avail[0][4])
		|=> pinOe[0][4] && !pinOut[0][4] && !pinWeakPullUp[0][4])
		else $error("quasi pin did not sink a latched zero");

	a_quasi_high: assert property ((regWr && regAddr == ADDR_P0_LATCH && regWrData[4] // R4
		&& !st.cfg1[0][4] && !st.cfg2[0][4] && avail[0][4])
		|=> !pinOe[0][4] && pinWeakPullUp[0][4])
		else $error("quasi pin did not drive a latched one weakly");

	a_pp_high: assert property ((regWr && regAddr == ADDR_P0_LATCH && regWrData[4] // R7
		&& !st.cfg1[0][4] && st.cfg2[0][4] && avail[0][4])
		|=> pinOe[0][4] && pinOut[0][4] && !pinWeakPullUp[0][4])
		else $error("push-pull pin did not drive a latched one");

	a_od_release: assert property ((regWr && regAddr == ADDR_P0_LATCH // R5
		&& st.cfg1[0][4] && st.cfg2[0][4])
		|=> (pinOe[0][4] == !$past(regWrData[4])) && !pinWeakPullUp[0][4] && !pinOut[0][4])
		else $error("open-drain pin drive does not follow the latch");

	a_inonly_off: assert property ((st.cfg1[0][4] && !st.cfg2[0][4] && !regWr) // R6
		|=> !pinOe[0][4] && !pinWeakPullUp[0][4])
		else $error("input-only pin has a driver on");

	a_cfg_store: assert property ((regWr && regAddr == ADDR_P0_CFG1) // R2
		|=> st.cfg1[0] == ($past(regWrData) & IMPL_MASK[0]))
		else $error("port 0 first configuration write not stored");

	a_rst_pin_input: assert property (!pinOe[RST_PORT][RST_BIT] // R3
		&& !pinWeakPullUp[RST_PORT][RST_BIT] && st.cfg1[RST_PORT][RST_BIT])
		else $error("reset-shared pin has a driver on");

	a_por_inonly: assert property ($fell(sys_rst) |-> (pinOe == '0) // R13
		&& (pinWeakPullUp == '0) && (st.cfg1 == IMPL_MASK))
		else $error("pins not input-only after reset");

	a_adis_clear: assert property ($fell(sys_rst) |-> (st.adis == '0) // R9
		&& (pinDigInEn == avail[0]))
		else $error("digital input disables not cleared by reset");

	a_avail_count: assert property ((st.clkSrc[1] && st.rstPinEn // R11
		|-> $countones(avail) == 3) and (st.clkSrc == CLK_ONCHIP && !st.rstPinEn
		|-> $countones(avail) == 6))
		else $error("usable pin count wrong for the options");

	a_read_input: assert property ((regRd && regAddr == ADDR_P0_INPUT) // R14
		|=> regRdData == $past(inVal[0]))
		else $error("port 0 input read does not show the filtered level");

	c_quasi_sink: cover property (regWr && regAddr == ADDR_P0_LATCH && !st.cfg1[0][4]
		&& !st.cfg2[0][4] ##1 pinOe[0][4]);
	c_pp_drive: cover property (pinOe[0][4] && pinOut[0][4]);
	c_adis_set: cover property (regWr && regAddr == ADDR_ADIS && regWrData[4]);
	c_input_read: cover property (regRd && regAddr == ADDR_P0_INPUT ##1 regRdData[4]);

endmodule

// >>> cfgio_pad_model.sv
// Pad and external circuit model for the configurable I/O port pins.
module cfgio_pad_model
	import cfgio_pkg::*;
(
	input  wire logic           clk_sys,       // System clock.
	input  wire cfgio_portvec_t pinOut,        // Strong drive level from the port.
	input  wire cfgio_portvec_t pinOe,         // Strong drive enable from the port.
	input  wire cfgio_portvec_t pinWeakPullUp, // Weak pull-up enable from the port.
	input  wire cfgio_portvec_t extEn,         // External device drives the pin.
	input  wire cfgio_portvec_t extLvl,        // Level the external device drives.
	output cfgio_portvec_t      pinIn          // Resolved pad level back to the port.
);
	logic floatLvl = 1'b0;

	// An undriven pad changes every cycle so that a stale value never reads as valid.
	always_ff @(posedge clk_sys) begin
		floatLvl <= ~floatLvl;
	end

	// A strong driver wins, an external device beats the weak pull-up.
	assign pinIn = (pinOe & pinOut) | (~pinOe & extEn & extLvl)
		| (~pinOe & ~extEn & (pinWeakPullUp | {(NUM_PORTS * PORT_W){floatLvl}}));
endmodule

// >>> cfgio_port_test.sv
// Self-checking testbench for the configurable I/O port block.
module cfgio_port_test
	import cfgio_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	localparam int FILT = 3;

	logic                clk_sys, sys_rst, regWr, regRd, resetPinEnable;
	logic [ADDR_W-1:0]   regAddr;
	logic [PORT_W-1:0]   regWrData, regRdData, pinDigInEn;
	logic [1:0]          clkSrcSel;
	cfgio_portvec_t      pinIn, pinOut, pinOe, pinWeakPullUp, extEn, extLvl;
	int                  failures, checkCount;

	cfgio_port #(.FILT_CYC(FILT)) cfgio_port_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
		.regRdData(regRdData), .clkSrcSel(clkSrcSel), .resetPinEnable(resetPinEnable),
		.pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .pinWeakPullUp(pinWeakPullUp),
		.pinDigInEn(pinDigInEn));

	cfgio_pad_model cfgio_pad_model_inst (.clk_sys(clk_sys), .pinOut(pinOut), .pinOe(pinOe),
		.pinWeakPullUp(pinWeakPullUp), .extEn(extEn), .extLvl(extLvl), .pinIn(pinIn));

	always #5 clk_sys = ~clk_sys;

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [23:0] expv, input logic [23:0] got);
		checkCount++;
		if (got !== expv) begin
			failures++;
			$display("mismatch %s expected %h seen %h", what, expv, got);
		end
	endtask

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [PORT_W-1:0] d);
		regAddr <= a;
		regWrData <= d;
		regWr <= 1'b1;
		@(posedge clk_sys);
		regWr <= 1'b0;
		@(posedge clk_sys);
		#1;
	endtask

	task automatic rdChk(input string what, input logic [ADDR_W-1:0] a,
		input logic [PORT_W-1:0] expv);
		logic [PORT_W-1:0] d;
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk_sys);
		regRd <= 1'b0;
		#1;
		d = regRdData;
		chk(what, {16'h0000, expv}, {16'h0000, d});
		@(posedge clk_sys);
		#1;
		chk("read idle", 24'h000000, {16'h0000, regRdData});
	endtask

	task automatic doReset(input logic [1:0] src, input logic rpe);
		clkSrcSel <= src;
		resetPinEnable <= rpe;
		sys_rst <= 1'b1;
		repeat (4) @(posedge clk_sys);
		sys_rst <= 1'b0;
		@(posedge clk_sys);
		#1;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic testDefaults();
		logic [ADDR_W-1:0] addrs [7] = '{4'h0, 4'h1, 4'h2, 4'h5, 4'h9, 4'hC, 4'hD};
		logic [PORT_W-1:0] vals [7] = '{8'h70, 8'h70, 8'h00, 8'h20, 8'h03, 8'h00, 8'h70};
		chk("oe", 24'h000000, pinOe);
		chk("weak", 24'h000000, pinWeakPullUp);
		wr(4'hD, 8'hFF);
		for (int i = 0; i < 7; i++) begin
			rdChk("default", addrs[i], vals[i]);
		end
	endtask

	task automatic testTypes();
		logic [PORT_W-1:0] lat, eOe, eOut, eWeak;
		cfgio_otype_t t;
		for (int i = 0; i < 8; i++) begin
			t = cfgio_otype_t'(i[1:0]);
			lat = i[2] ? 8'h70 : 8'h00;
			wr(ADDR_P0_CFG1, t[1] ? 8'h70 : 8'h00);
			wr(4'h2, t[0] ? 8'h70 : 8'h00);
			wr(ADDR_P0_LATCH, lat);
			eOe = (t == CFGIO_PUSHPULL || (t != CFGIO_INONLY && lat == 8'h00)) ? 8'h70 : 8'h00;
			eOut = (t == CFGIO_PUSHPULL) ? lat : 8'h00;
			eWeak = (t == CFGIO_QUASI) ? lat : 8'h00;
			chk("type oe", {16'h0000, eOe}, {16'h0000, pinOe[0]});
			chk("type out", {16'h0000, eOut & eOe}, {16'h0000, pinOut[0] & pinOe[0]});
			chk("type weak", {16'h0000, eWeak}, {16'h0000, pinWeakPullUp[0]});
		end
	endtask

	task automatic testResetPin();
		wr(4'h5, 8'h00);
		wr(4'h6, 8'hFF);
		wr(4'h4, 8'h00);
		rdChk("rst pin cfg1", 4'h5, 8'h20);
		rdChk("rst pin cfg2", 4'h6, 8'h00);
		chk("rst pin drive", 24'h000000, {pinOe[1], pinWeakPullUp[1], 8'h00});
	endtask

	task automatic testInput();
		wr(4'h9, 8'h00);
		repeat (20) @(posedge clk_sys);
		#1;
		rdChk("pulled high", 4'hB, 8'h03);
		extEn[2][0] <= 1'b1;
		extLvl[2][0] <= 1'b0;
		repeat (FILT - 1) @(posedge clk_sys);
		extEn[2][0] <= 1'b0;
		repeat (20) @(posedge clk_sys);
		#1;
		rdChk("glitch", 4'hB, 8'h03);
		extEn[2][0] <= 1'b1;
		repeat (20) @(posedge clk_sys);
		#1;
		rdChk("held low", 4'hB, 8'h02);
		chk("weak kept", 24'h000001, {23'h0, pinWeakPullUp[2][0]});
	endtask

	task automatic testDisable();
		extEn[0] <= 8'h70;
		extLvl[0] <= 8'h70;
		repeat (20) @(posedge clk_sys);
		#1;
		rdChk("p0 in", ADDR_P0_INPUT, 8'h70);
		wr(ADDR_ADIS, 8'h10);
		chk("dig en", 24'h000060, {16'h0000, pinDigInEn});
		rdChk("p0 dis", ADDR_P0_INPUT, 8'h60);
		rdChk("dis reg", ADDR_ADIS, 8'h10);
		doReset(CLK_ONCHIP, 1'b0);
		rdChk("dis reset", ADDR_ADIS, 8'h00);
		chk("dig en reset", 24'h000070, {16'h0000, pinDigInEn});
	endtask

	task automatic testStraps();
		int counts [8] = '{6, 5, 5, 4, 4, 3, 4, 3};
		logic [PORT_W-1:0] m [3];
		for (int i = 0; i < 8; i++) begin
			doReset(i[2:1], i[0]);
			for (int s = 0; s < 3; s++) begin
				regAddr <= ADDR_AVAIL_P0 + ADDR_W'(s);
				regRd <= 1'b1;
				@(posedge clk_sys);
				regRd <= 1'b0;
				#1;
				m[s] = regRdData;
				@(posedge clk_sys);
				#1;
			end
			chk("pin count", 24'(counts[i]), 24'($countones({m[0], m[1], m[2]})));
		end
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic give_verdict();
		$display("checks %0d failures %0d", checkCount, failures);
		if (failures == 0 && checkCount > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	initial begin
		clk_sys = 1'b0;
		sys_rst = 1'b1;
		regWr = 1'b0;
		regRd = 1'b0;
		regAddr = '0;
		regWrData = '0;
		clkSrcSel = CLK_ONCHIP;
		resetPinEnable = 1'b0;
		extEn = '0;
		extLvl = '0;
		failures = 0;
		checkCount = 0;
		@(posedge clk_sys);
		doReset(CLK_ONCHIP, 1'b0);
		testDefaults();
		testTypes();
		testResetPin();
		testInput();
		testDisable();
		testStraps();
		give_verdict();
	end

	initial begin
		repeat (20000) @(posedge clk_sys);
		failures++;
		give_verdict();
	end
endmodule
